//--- hdl/ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_ADDR_DATA 8'h21
`define SSP_ADDR_CTRL 8'h22
`define SSP_ADDR_STAT 8'h23
`define SSP_CR_IE 7
`define SSP_CR_PE 6
`define SSP_CR_R2 5
`define SSP_CR_MS 4
`define SSP_CR_POL 3
`define SSP_CR_PHA 2
`define SSP_CR_R1 1
`define SSP_CR_R0 0
`define SSP_SR_DONE 7
`define SSP_SR_WRITE_COLLISION_FLAG 6
`define SSP_SR_MODE_FAULT_FLAG 4
`define SSP_CR_RESET 8'h00
`define SSP_DR_RESET 8'h00
`define SSP_RD_IDLE 8'h00
`define SSP_LAST_EDGE 4'hf
`define SSP_HALF_2 7'h01
`define SSP_HALF_8 7'h04
`define SSP_HALF_16 7'h08
`define SSP_HALF_32 7'h10
`define SSP_HALF_64 7'h20
`define SSP_HALF_128 7'h40
`endif

//--- hdl/ssp_pkg.sv
package ssp_pkg;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } ssp_pins_t;

  typedef enum logic {
    ssp_idle = 1'b0,
    ssp_xfer = 1'b1
  } ssp_xfer_st_t;

  typedef struct packed {
    logic [7:0] control_reg;
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic done_armed;
    logic write_collision_flag_armed;
    logic mode_fault_flag_armed;
    logic [7:0] shreg;
    logic [7:0] rxbuf;
    logic rxbit;
    logic [3:0] edge_cnt;
    ssp_xfer_st_t st;
    logic [6:0] div_cnt;
    logic sck_lvl;
    logic sck_pin;
    ssp_pins_t sync1;
    ssp_pins_t sync2;
    logic sck_prev;
    logic [7:0] rdata;
  } ssp_state_t;

endpackage

//--- hdl/ssp_regs.sv
`include "ssp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module ssp_regs #(
  parameter int unsigned BYTE_BITS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic global_irq_mask,
  input wire logic halt_mode,
  output logic irq_req,
  input wire ssp_pkg::ssp_pins_t pin_in,
  output var ssp_pkg::ssp_pins_t pin_out,
  output var ssp_pkg::ssp_pins_t pin_oe_n
);

  if (BYTE_BITS != 8)
  begin : g_chk
    $error("ssp_regs serves 8-bit bytes only");
  end

  ssp_pkg::ssp_state_t s_r;
  ssp_pkg::ssp_state_t s_nxt;

  logic pe;
  logic ms;
  logic pha;
  logic active_master;
  logic active_slave;
  logic [6:0] half;
  logic div_tick;
  logic edge_now;
  logic rx_in;
  logic busy;
  logic dr_wr;
  logic dr_rd;
  logic cr_wr;
  logic sr_acc;
  logic sr_rd;
  logic mode_fault;

  function automatic logic [6:0] half_of(input logic [2:0] r);
    logic [6:0] h;
    h = `SSP_HALF_128;
    unique case (r)
      3'h4: h = `SSP_HALF_2;
      3'h0: h = `SSP_HALF_8;
      3'h1: h = `SSP_HALF_16;
      3'h6: h = `SSP_HALF_32;
      3'h2: h = `SSP_HALF_64;
      3'h3: h = `SSP_HALF_128;
      // Unlisted codes run at the slowest rate
      default: h = `SSP_HALF_128;
    endcase
    return h;
  endfunction

  assign pe = s_r.control_reg[`SSP_CR_PE];
  assign ms = s_r.control_reg[`SSP_CR_MS];
  assign pha = s_r.control_reg[`SSP_CR_PHA];
  assign active_master = pe & ms;
  assign active_slave = pe & ~ms & ~s_r.sync2.ss_n;
  assign half = half_of({s_r.control_reg[`SSP_CR_R2], s_r.control_reg[`SSP_CR_R1],
                         s_r.control_reg[`SSP_CR_R0]});
  assign div_tick = (s_r.div_cnt == half - 7'h01);
  // Slave edges come from the synchronised pin, master edges from the divider
  assign edge_now = ms ? (active_master & (s_r.st == ssp_pkg::ssp_xfer) & div_tick)
                       : (active_slave & (s_r.sync2.sck ^ s_r.sck_prev));
  assign rx_in = ms ? s_r.sync2.miso : s_r.sync2.mosi;
  // First-edge capture slave is committed as soon as select goes low
  assign busy = (s_r.st == ssp_pkg::ssp_xfer) | (active_slave & ~pha);
  assign dr_wr = reg_wr & (reg_addr == `SSP_ADDR_DATA);
  assign dr_rd = reg_rd & (reg_addr == `SSP_ADDR_DATA);
  assign cr_wr = reg_wr & (reg_addr == `SSP_ADDR_CTRL);
  assign sr_rd = reg_rd & (reg_addr == `SSP_ADDR_STAT);
  assign sr_acc = (reg_rd | reg_wr) & (reg_addr == `SSP_ADDR_STAT);
  assign mode_fault = active_master & ~s_r.sync2.ss_n;

  always_comb
  begin
    logic cap;
    logic [7:0] fin;
    logic clr_done;
    logic clr_write_collision_flag;
    logic clr_mode_fault_flag;
    cap = 1'b0;
    fin = 8'h00;
    clr_done = 1'b0;
    clr_write_collision_flag = 1'b0;
    clr_mode_fault_flag = 1'b0;
    s_nxt = s_r;
    s_nxt.sync1 = pin_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sck_prev = s_r.sync2.sck;
    s_nxt.rdata = `SSP_RD_IDLE;
    // Halt freezes everything but the pin synchronisers and the read data, which returns to idle
    if (!halt_mode)
    begin
      if (reg_rd)
      begin
        unique case (reg_addr)
          `SSP_ADDR_DATA: s_nxt.rdata = s_r.rxbuf;
          `SSP_ADDR_CTRL: s_nxt.rdata = s_r.control_reg;
          `SSP_ADDR_STAT: s_nxt.rdata = {s_r.transfer_done_flag, s_r.write_collision_flag,
                                         1'b0, s_r.mode_fault_flag, 4'h0};
          default: s_nxt.rdata = `SSP_RD_IDLE;
        endcase
      end

      // Clearing sequences: arm on status access (status read for collision), fire on a data access (control write for mode fault)
      if (sr_acc && s_r.transfer_done_flag)
      begin
        s_nxt.done_armed = 1'b1;
      end
      if (sr_rd && s_r.write_collision_flag)
      begin
        s_nxt.write_collision_flag_armed = 1'b1;
      end
      if (sr_acc && s_r.mode_fault_flag)
      begin
        s_nxt.mode_fault_flag_armed = 1'b1;
      end
      clr_done = (dr_rd | dr_wr) & s_r.done_armed;
      clr_write_collision_flag = (dr_rd | dr_wr) & s_r.write_collision_flag_armed;
      clr_mode_fault_flag = cr_wr & s_r.mode_fault_flag_armed;
      if (clr_done)
      begin
        s_nxt.transfer_done_flag = 1'b0;
        s_nxt.done_armed = 1'b0;
      end
      if (clr_write_collision_flag)
      begin
        s_nxt.write_collision_flag = 1'b0;
        s_nxt.write_collision_flag_armed = 1'b0;
      end
      if (clr_mode_fault_flag)
      begin
        s_nxt.mode_fault_flag = 1'b0;
        s_nxt.mode_fault_flag_armed = 1'b0;
      end

      if (cr_wr)
      begin
        s_nxt.control_reg = reg_wdata;
        if (s_r.mode_fault_flag && !s_r.mode_fault_flag_armed)
        begin
          s_nxt.control_reg[`SSP_CR_PE] = 1'b0;
          s_nxt.control_reg[`SSP_CR_MS] = 1'b0;
        end
      end

      // Data writes: ignored while done, collide while busy, else load
      if (dr_wr && !s_r.transfer_done_flag)
      begin
        if (busy)
        begin
          s_nxt.write_collision_flag = 1'b1;
        end
        else
        begin
          s_nxt.shreg = reg_wdata;
          if (active_master)
          begin
            s_nxt.st = ssp_pkg::ssp_xfer;
            s_nxt.div_cnt = 7'h00;
            s_nxt.edge_cnt = 4'h0;
            s_nxt.sck_lvl = 1'b0;
          end
        end
      end

      if (ms && s_r.st == ssp_pkg::ssp_xfer)
      begin
        s_nxt.div_cnt = div_tick ? 7'h00 : s_r.div_cnt + 7'h01;
      end

      // Sixteen edges make eight pulses; capture and shift alternate
      if (edge_now)
      begin
        cap = (s_r.edge_cnt[0] == pha);
        s_nxt.st = ssp_pkg::ssp_xfer;
        s_nxt.edge_cnt = s_r.edge_cnt + 4'h1;
        if (ms)
        begin
          s_nxt.sck_lvl = ~s_r.sck_lvl;
        end
        if (cap)
        begin
          s_nxt.rxbit = rx_in;
        end
        else if (!(pha && s_r.edge_cnt == 4'h0))
        begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.rxbit};
        end
        if (s_r.edge_cnt == `SSP_LAST_EDGE)
        begin
          fin = cap ? {s_r.shreg[6:0], rx_in} : {s_r.shreg[6:0], s_r.rxbit};
          // Received byte stays in the shifter and echoes next time
          s_nxt.shreg = fin;
          s_nxt.st = ssp_pkg::ssp_idle;
          s_nxt.edge_cnt = 4'h0;
          s_nxt.sck_lvl = 1'b0;
          // Overrun bytes are silently dropped, nothing reports them
          if (!s_r.transfer_done_flag || clr_done)
          begin
            s_nxt.rxbuf = fin;
          end
          s_nxt.transfer_done_flag = 1'b1;
          s_nxt.done_armed = 1'b0;
        end
      end

      // Select released mid-byte abandons a slave transfer
      if (!ms && s_r.sync2.ss_n)
      begin
        s_nxt.st = ssp_pkg::ssp_idle;
        s_nxt.edge_cnt = 4'h0;
      end

      if (mode_fault)
      begin
        s_nxt.mode_fault_flag = 1'b1;
        s_nxt.mode_fault_flag_armed = 1'b0;
        s_nxt.control_reg[`SSP_CR_PE] = 1'b0;
        s_nxt.control_reg[`SSP_CR_MS] = 1'b0;
        s_nxt.st = ssp_pkg::ssp_idle;
        s_nxt.edge_cnt = 4'h0;
        s_nxt.div_cnt = 7'h00;
        s_nxt.sck_lvl = 1'b0;
      end
      s_nxt.sck_pin = s_nxt.control_reg[`SSP_CR_POL] ^ s_nxt.sck_lvl;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.control_reg <= `SSP_CR_RESET;
      s_r.rxbuf <= `SSP_DR_RESET;
      s_r.shreg <= `SSP_DR_RESET;
      s_r.sync1 <= '1;
      s_r.sync2 <= '1;
      s_r.rdata <= `SSP_RD_IDLE;
      s_r.st <= ssp_pkg::ssp_idle;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // One shared line; wait exit is the CPU's use of this request
  assign irq_req = s_r.control_reg[`SSP_CR_IE] & ~global_irq_mask &
                   (s_r.transfer_done_flag | s_r.mode_fault_flag);
  assign reg_rdata = s_r.rdata;

  assign pin_out.sck = s_r.sck_pin;
  assign pin_out.mosi = s_r.shreg[7];
  assign pin_out.miso = s_r.shreg[7];
  assign pin_out.ss_n = 1'b1;
  assign pin_oe_n.sck = ~active_master;
  assign pin_oe_n.mosi = ~active_master;
  // Slave drives its output only while selected
  assign pin_oe_n.miso = ~active_slave;
  assign pin_oe_n.ss_n = 1'b1;

endmodule // ssp_regs

`default_nettype wire

//--- verification/ssp_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_regs_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic global_irq_mask,
  input wire logic halt_mode,
  input wire logic irq_req,
  input wire ssp_pkg::ssp_pins_t pin_in,
  input wire ssp_pkg::ssp_pins_t pin_out,
  input wire ssp_pkg::ssp_pins_t pin_oe_n
);
  // Bit 1 status read, bit 0 control read, one cycle late
  logic [1:0] rd_r;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      rd_r <= 2'b00;
    else
      rd_r <= {reg_addr == 8'h23, reg_addr == 8'h22} & {2{reg_rd && !halt_mode}};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  stat_quiet_a: assert property (rd_r[1] |-> {reg_rdata[5], reg_rdata[3:0]} == 5'h00)
    else $error("unused status bit set");
  irq_mask_a: assert property (global_irq_mask |-> !irq_req)
    else $error("request while masked");
  irq_enable_a: assert property (rd_r[0] && !reg_rdata[7] |-> !irq_req)
    else $error("request while disabled");
  pin_dir_a: assert property (!pin_oe_n.sck |-> !pin_oe_n.mosi && pin_oe_n.miso)
    else $error("master pin directions wrong");
  fault_drop_a: assert property (!pin_oe_n.sck && !pin_in.ss_n |-> ##[1:4] pin_oe_n.sck)
    else $error("master kept pins under fault");
  fault_off_a: assert property (rd_r[1] && reg_rdata[4] |-> pin_oe_n.sck && pin_oe_n.ss_n)
    else $error("pins driven with fault set");
  halt_hold_a: assert property ($past(halt_mode) |-> $stable(pin_out) && $stable(pin_oe_n))
    else $error("pins moved in halt");
endmodule // ssp_regs_monitor
bind ssp_regs ssp_regs_monitor mon (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .global_irq_mask, .halt_mode, .irq_req, .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

//--- verification/ssp_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_peer_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic clock_phase_sel,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [8:0] sh;
  logic odd;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  // Phase 1 preloads a dummy bit so the first edge exposes the MSB
  always @(negedge ss_n)
  begin
    odd = 1'b0;
    sh = clock_phase_sel ? {~tx_byte[7], tx_byte} : {tx_byte, 1'b0};
    miso = sh[8];
  end
  // Released line must not keep the last bit
  always @(posedge ss_n)
    miso = ~miso;
  always @(sck)
    if (!ss_n)
    begin
      odd = ~odd;
      if (odd ^ clock_phase_sel)
        rx_byte = {rx_byte[6:0], mosi};
      else
      begin
        sh = sh << 1;
        miso = sh[8];
      end
    end
endmodule // ssp_peer_model
`default_nettype wire

//--- verification/test_ssp_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_ssp_regs;
  logic core_clk, rst_n, reg_wr, reg_rd, global_irq_mask, halt_mode, irq_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, stx, srx, q;
  ssp_pkg::ssp_pins_t pin_in, pin_out, pin_oe_n;
  logic tb_sck, tb_mosi, ss_n, sel_n, s_miso, pha;
  int n_mismatch, comparisons, n;
  logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
  int half [6] = '{1, 4, 8, 16, 32, 64};
  ssp_regs dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .global_irq_mask, .halt_mode, .irq_req, .pin_in, .pin_out, .pin_oe_n);
  ssp_peer_model peer (.sck(pin_in.sck), .mosi(pin_in.mosi), .ss_n(sel_n), .clock_phase_sel(pha),
    .tx_byte(stx), .miso(s_miso), .rx_byte(srx));
  assign pin_in.sck = pin_oe_n.sck ? tb_sck : pin_out.sck;
  assign pin_in.mosi = pin_oe_n.mosi ? tb_mosi : pin_out.mosi;
  assign pin_in.miso = pin_oe_n.miso ? s_miso : pin_out.miso;
  assign pin_in.ss_n = ss_n;
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
    @(posedge core_clk);
  endtask
  task automatic wirq(output int c);
    c = 0;
    #1;
    while (irq_req !== 1'b1 && c < 3000)
    begin
      @(posedge core_clk);
      #1 c = c + 1;
    end
    @(posedge core_clk);
  endtask
  // Link master, mode 0; slave needs several core cycles per level
  task automatic sx(input logic [7:0] d, output logic [7:0] r);
    #3 ss_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      tb_mosi = d[i];
      #40 tb_sck = 1'b1;
      r[i] = pin_in.miso;
      #40 tb_sck = 1'b0;
    end
    #40 ss_n = 1'b1;
    #80 @(posedge core_clk);
  endtask
  task automatic results();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #500000 n_mismatch++;
    results();
  end
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, global_irq_mask, halt_mode} = '0;
    {tb_sck, tb_mosi, pha, stx, ss_n, sel_n} = 13'h0003;
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      pha = i[0];
      stx = 8'h3c ^ 8'(i);
      wr(8'h22, {2'b11, code[i][2], 1'b1, i[1], i[0], code[i][1:0]});
      sel_n = 1'b0;
      wr(8'h21, 8'ha5 ^ 8'(i));
      if (i == 1)
        wr(8'h21, 8'h11);
      wirq(n);
      chk("cycles", 16'(16 * half[i] - ((i == 1) ? 3 : 1)), 16'(n));
      sel_n = 1'b1;
      rd(8'h23, (i == 1) ? 8'hc0 : 8'h80);
      if (i == 0)
        wr(8'h21, 8'h00);
      else
        rd(8'h21, stx);
      rd(8'h23, 8'h00);
      chk("peer", {8'h00, 8'ha5 ^ 8'(i)}, {8'h00, srx});
      chk("idle", {15'h0, i[1]}, {15'h0, pin_out.sck});
    end
    ss_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1 chk("irq", 16'h1, {15'h0, irq_req});
    @(posedge core_clk);
    global_irq_mask <= 1'b1;
    @(posedge core_clk);
    #1 chk("mask", 16'h0, {15'h0, irq_req});
    @(posedge core_clk);
    global_irq_mask <= 1'b0;
    wr(8'h22, 8'hd0);
    rd(8'h22, 8'h80);
    rd(8'h23, 8'h10);
    ss_n <= 1'b1;
    wr(8'h22, 8'h63);
    rd(8'h23, 8'h00);
    sx(8'h5a, q);
    sx(8'hc3, q);
    rd(8'h23, 8'h80);
    rd(8'h21, 8'h5a);
    sx(8'h00, q);
    chk("echo", 16'h00c3, {8'h00, q});
    rd(8'h23, 8'h80);
    rd(8'h21, 8'h00);
    ss_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(8'h21, 8'h77);
    rd(8'h23, 8'h40);
    ss_n <= 1'b1;
    // Select must settle through the synchroniser before halt freezes the pins
    repeat (3) @(posedge core_clk);
    halt_mode <= 1'b1;
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h00);
    halt_mode <= 1'b0;
    rd(8'h22, 8'h63);
    results();
  end
endmodule // test_ssp_regs
`default_nettype wire
